//--- hw/sgt_pkg.sv
// package for the sweep gate and trigger control block
package sgt_pkg;
  // ----------------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_NS = 125;
  localparam int unsigned TICK_CYC = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int TW = 32;
  // times in 125 ns ticks
  localparam logic [31:0] GATE_DLY_MAX = 32'h0e4e_1c00;
  localparam logic [31:0] GATE_LEN_MIN = 32'h0000_0001;
  localparam logic [31:0] GATE_LEN_RST = 32'h0000_0c80;
  localparam logic [31:0] TRIG_OFS_MAX = 32'h04c4_b400;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] A_FILT = 4'h0;
  localparam logic [3:0] A_RBW = 4'h1;
  localparam logic [3:0] A_CPL = 4'h2;
  localparam logic [3:0] A_GCTL = 4'h3;
  localparam logic [3:0] A_GDLY = 4'h4;
  localparam logic [3:0] A_GLEN = 4'h5;
  localparam logic [3:0] A_TCTL = 4'h6;
  localparam logic [3:0] A_TOFS = 4'h7;
  localparam logic [3:0] A_STAT = 4'h8;
  localparam logic [3:0] A_SWP = 4'h9;
  localparam logic [3:0] A_CMD = 4'ha;
  // bits
  localparam int B_SPAN_BANDWIDTH_LINK = 0;
  localparam int B_AUTO = 1;
  localparam int B_GEN = 0;
  localparam int B_GLVL = 1;
  localparam int B_GNEG = 2;
  localparam int B_TNEG = 0;
  localparam int B_TDOM = 1;
  localparam int B_CMD_ARM = 0;
  // filter codes
  localparam logic [1:0] F_CHAN = 2'h0;
  localparam logic [1:0] F_GAUSS = 2'h1;
  localparam logic [1:0] F_WEIGHT = 2'h2;
  localparam logic [1:0] F_DEF6 = 2'h3;
  localparam logic [1:0] F_WEIGHT_ALT = 2'h2;
  // trigger sources
  localparam logic [1:0] S_IMM = 2'h0;
  localparam logic [1:0] S_EXT = 2'h1;
  localparam logic [1:0] S_IFP = 2'h2;
  // detectors that allow frequency coupling, then bandwidth step at reset and top step
  localparam logic [1:0] D_QP = 2'h1;
  localparam logic [1:0] D_AVG = 2'h2;
  localparam logic [1:0] D_RMS = 2'h3;
  localparam logic [3:0] RBW_RST = 4'h6;
  localparam logic [3:0] RBW_TOP = 4'hf;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sgt_bus_t;

  typedef struct packed {
    logic gate_open;
    logic capture;
    logic busy_hold;
    logic freq_cpl;
    logic span_link;
  } sgt_stat_t;
endpackage : sgt_pkg

//--- hw/sgt_ctrl.sv
// sweep gate, trigger and bandwidth control
`timescale 1ns/100ps
module sgt_ctrl (
  input wire logic MCLK,
  input wire logic NRST,
  input wire sgt_pkg::sgt_bus_t BUS,
  input wire logic [1:0] DETECTOR,
  input wire logic [31:0] SWEEP_TICKS,
  input wire logic EXT_IN,
  input wire logic SAMPLE_IN,
  output logic [31:0] RDATA,
  output sgt_pkg::sgt_stat_t STATUS,
  output logic SAMPLE_OK
);
  import sgt_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [1:0] filt_ff;
  logic [3:0] rbw_ff;
  logic span_bandwidth_link_ff, auto_ff;
  logic gen_ff, glvl_ff, gneg_ff;
  logic [31:0] gdly_ff, glen_ff;
  logic [1:0] src_ff;
  logic tneg_ff, tdom_ff;
  logic signed [31:0] tofs_ff;
  logic [3:0] tick_ff;
  logic [2:0] sy_ff;
  logic ext_ff;
  logic gate_ff, cap_ff, hold_ff, ok_ff;
  logic [31:0] gcnt_ff, lcnt_ff, tcnt_ff;
  logic dly_ff;
  logic [31:0] rd_ff;

  // available bandwidth steps per filter: bit set means step allowed
  function automatic logic [15:0] bw_mask(input logic [1:0] f);
    unique case (f)
      F_CHAN: bw_mask = 16'hfff0;
      F_GAUSS: bw_mask = 16'hffff;
      F_WEIGHT: bw_mask = 16'h0aa8;
      F_DEF6: bw_mask = 16'h5554;
    endcase
  endfunction : bw_mask

  // next step at or above b that the filter offers, else top
  function automatic logic [3:0] bw_fit(input logic [1:0] f,
                                         input logic [3:0] b);
    logic [15:0] m;
    logic [3:0] r;
    logic hit;
    m = bw_mask(f);
    r = RBW_TOP;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!hit && i >= int'(b) && m[i]) begin
        r = 4'(i);
        hit = 1'b1;
      end
    end
    bw_fit = r;
  endfunction : bw_fit

  function automatic logic [31:0] clip(input logic [31:0] v,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire wr = BUS.wr & ~hold_ff;
  wire w_filt = wr && BUS.addr == A_FILT;
  wire w_rbw = wr && BUS.addr == A_RBW;
  wire w_cpl = wr && BUS.addr == A_CPL;
  wire w_gctl = wr && BUS.addr == A_GCTL;
  wire w_gdly = wr && BUS.addr == A_GDLY;
  wire w_glen = wr && BUS.addr == A_GLEN;
  wire w_tctl = wr && BUS.addr == A_TCTL;
  wire w_tofs = wr && BUS.addr == A_TOFS;
  wire w_arm = wr && BUS.addr == A_CMD && BUS.wdata[B_CMD_ARM];
  wire [1:0] nxt_filt = BUS.wdata[1:0];
  wire [3:0] nxt_rbw = w_filt ? bw_fit(nxt_filt, rbw_ff)
                              : bw_fit(filt_ff, BUS.wdata[3:0]);
  wire ext_src = src_ff == S_EXT || src_ff == S_IFP;
  // shared input: with source S_EXT or S_IFP, gate delay adds to trigger offset
  wire signed [31:0] eff_ofs = ext_src ? tofs_ff + signed'(gdly_ff)
                                       : tofs_ff;
  wire signed [31:0] neg_lim = -signed'(SWEEP_TICKS);
  wire signed [31:0] wofs = signed'(BUS.wdata);
  wire signed [31:0] lo_ofs = tdom_ff ? neg_lim : 32'sh0;
  wire signed [31:0] nxt_tofs = wofs < lo_ofs ? lo_ofs
    : (wofs > signed'(TRIG_OFS_MAX) ? signed'(TRIG_OFS_MAX) : wofs);
  wire det_ok = DETECTOR == D_QP || DETECTOR == D_AVG
             || DETECTOR == D_RMS;
  wire tick = tick_ff == 4'(TICK_CYC - 1);
  // a change counts only once stages two and three agree
  wire ext_lvl = (sy_ff[2] == sy_ff[1]) ? sy_ff[1] : ext_ff;
  wire act = ext_lvl ^ gneg_ff;
  wire act_prev = ext_ff ^ gneg_ff;
  wire gate_edge = act & ~act_prev;
  wire trig_edge = (ext_lvl ^ tneg_ff) & ~(ext_ff ^ tneg_ff);

  // ----------------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      filt_ff <= F_GAUSS;
      rbw_ff <= RBW_RST;
      span_bandwidth_link_ff <= 1'b1;
      auto_ff <= 1'b1;
      gen_ff <= 1'b0;
      glvl_ff <= 1'b0;
      gneg_ff <= 1'b0;
      gdly_ff <= 32'h0;
      glen_ff <= GATE_LEN_RST;
      src_ff <= S_IMM;
      tneg_ff <= 1'b0;
      tdom_ff <= 1'b0;
      tofs_ff <= 32'sh0;
    end else begin
      if (w_filt) filt_ff <= nxt_filt;
      if (w_filt || w_rbw) rbw_ff <= nxt_rbw;
      if (w_rbw) auto_ff <= 1'b0;
      else if (w_cpl) auto_ff <= BUS.wdata[B_AUTO];
      if (w_cpl) span_bandwidth_link_ff <= BUS.wdata[B_SPAN_BANDWIDTH_LINK];
      if (w_gctl) begin
        gen_ff <= BUS.wdata[B_GEN];
        glvl_ff <= BUS.wdata[B_GLVL];
        gneg_ff <= BUS.wdata[B_GNEG];
      end
      if (w_gdly) gdly_ff <= clip(BUS.wdata, 32'h0, GATE_DLY_MAX);
      if (w_glen) glen_ff <= clip(BUS.wdata, GATE_LEN_MIN, GATE_DLY_MAX);
      if (w_tctl) begin
        tneg_ff <= BUS.wdata[B_TNEG];
        tdom_ff <= BUS.wdata[B_TDOM];
        src_ff <= BUS.wdata[3:2];
      end
      if (w_tofs) tofs_ff <= nxt_tofs;
    end
  end

  // ----------------------------------------------------------------------
  // input sync and time base
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sy_ff <= 3'h0;
      ext_ff <= 1'b0;
      tick_ff <= 4'h0;
    end else begin
      sy_ff <= {sy_ff[1:0], EXT_IN};
      ext_ff <= ext_lvl;
      tick_ff <= tick ? 4'h0 : tick_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // gate
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      gate_ff <= 1'b0;
      dly_ff <= 1'b0;
      gcnt_ff <= 32'h0;
      lcnt_ff <= 32'h0;
    end else if (!gen_ff) begin
      gate_ff <= 1'b0;
      dly_ff <= 1'b0;
    end else if (glvl_ff) begin
      gate_ff <= act;
      if (gate_edge) begin
        dly_ff <= gdly_ff != 32'h0;
        gcnt_ff <= gdly_ff;
      end else if (dly_ff && tick) begin
        if (gcnt_ff <= 32'h1) dly_ff <= 1'b0;
        gcnt_ff <= gcnt_ff - 32'h1;
      end
    end else begin
      if (gate_edge) begin
        gate_ff <= 1'b1;
        dly_ff <= gdly_ff != 32'h0;
        gcnt_ff <= gdly_ff;
        lcnt_ff <= glen_ff;
      end else if (tick) begin
        if (dly_ff) begin
          if (gcnt_ff <= 32'h1) dly_ff <= 1'b0;
          gcnt_ff <= gcnt_ff - 32'h1;
        end else if (gate_ff) begin
          if (lcnt_ff <= 32'h1) gate_ff <= 1'b0;
          lcnt_ff <= lcnt_ff - 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // trigger and capture
  // ----------------------------------------------------------------------
  wire signed [31:0] wait_ticks = eff_ofs < 0 ? 32'sh0 : eff_ofs;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      hold_ff <= 1'b0;
      cap_ff <= 1'b0;
      tcnt_ff <= 32'h0;
    end else if (w_arm) begin
      hold_ff <= ext_src;
      cap_ff <= ~ext_src & (wait_ticks == 0);
      tcnt_ff <= ext_src ? 32'hffff_ffff : 32'(wait_ticks);
    end else if (hold_ff && trig_edge) begin
      hold_ff <= 1'b0;
      tcnt_ff <= 32'(wait_ticks);
      cap_ff <= wait_ticks == 0;
    end else if (!hold_ff && tcnt_ff != 32'h0 && tick) begin
      tcnt_ff <= tcnt_ff - 32'h1;
      cap_ff <= tcnt_ff == 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // read port and outputs
  // ----------------------------------------------------------------------
  wire [31:0] rmux =
    BUS.addr == A_FILT ? {30'h0, filt_ff} :
    BUS.addr == A_RBW ? {28'h0, rbw_ff} :
    BUS.addr == A_CPL ? {30'h0, auto_ff, span_bandwidth_link_ff} :
    BUS.addr == A_GCTL ? {29'h0, gneg_ff, glvl_ff, gen_ff} :
    BUS.addr == A_GDLY ? gdly_ff :
    BUS.addr == A_GLEN ? glen_ff :
    BUS.addr == A_TCTL ? {28'h0, src_ff, tdom_ff, tneg_ff} :
    BUS.addr == A_TOFS ? tofs_ff :
    BUS.addr == A_STAT ? {27'h0, STATUS} : 32'h0;
  wire open_now = gate_ff & ~dly_ff;
  wire nxt_ok = SAMPLE_IN & (~gen_ff | open_now);
  wire nxt_fcpl = auto_ff & det_ok;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rd_ff <= 32'h0;
      ok_ff <= 1'b0;
      STATUS <= '0;
    end else begin
      rd_ff <= BUS.rd ? rmux : 32'h0;
      ok_ff <= nxt_ok;
      STATUS <= '{gate_open: open_now, capture: cap_ff, busy_hold: hold_ff,
                  freq_cpl: nxt_fcpl, span_link: span_bandwidth_link_ff};
    end
  end
  assign RDATA = rd_ff;
  assign SAMPLE_OK = ok_ff;

  a_rbw_uncouple: assert property (
    @(posedge MCLK) disable iff (!NRST) w_rbw |=> !auto_ff)
    else $error("coupling kept");
  a_hold_write: assert property (
    @(posedge MCLK) disable iff (!NRST)
    hold_ff && BUS.wr && BUS.addr == A_GDLY |=> $stable(gdly_ff))
    else $error("write in hold");
  a_gate_off: assert property (
    @(posedge MCLK) disable iff (!NRST) !gen_ff |=> !gate_ff)
    else $error("gate while off");
  a_sample_gate: assert property (
    @(posedge MCLK) disable iff (!NRST) gen_ff && !open_now |=> !SAMPLE_OK)
    else $error("sample out");
  a_bw_valid: assert property (
    @(posedge MCLK) disable iff (!NRST)
    w_filt |=> |(bw_mask(filt_ff) & (16'h1 << rbw_ff)) || rbw_ff == RBW_TOP)
    else $error("bad bw");
  a_gdly_max: assert property (
    @(posedge MCLK) disable iff (!NRST) gdly_ff <= GATE_DLY_MAX)
    else $error("delay range");
  a_glen_min: assert property (
    @(posedge MCLK) disable iff (!NRST) glen_ff >= GATE_LEN_MIN)
    else $error("length range");
  a_lvl_gate: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (gen_ff && glvl_ff) ##1 (gen_ff && glvl_ff) |-> gate_ff == $past(act))
    else $error("level gate");
  a_cap_now: assert property (
    @(posedge MCLK) disable iff (!NRST)
    hold_ff && trig_edge && wait_ticks == 0 |=> cap_ff)
    else $error("late capture");
  a_arm_hold: assert property (
    @(posedge MCLK) disable iff (!NRST) w_arm && ext_src |=> hold_ff)
    else $error("no hold on arm");
  a_span_write: assert property (
    @(posedge MCLK) disable iff (!NRST)
    w_cpl |=> span_bandwidth_link_ff == $past(BUS.wdata[B_SPAN_BANDWIDTH_LINK]))
    else $error("span link");
  c_edge_gate: cover property (@(posedge MCLK) gen_ff && gate_edge);
  c_ext_trig: cover property (@(posedge MCLK) hold_ff && trig_edge);
  c_capture: cover property (@(posedge MCLK) $rose(cap_ff));
endmodule : sgt_ctrl

//--- testbench/sgt_ext_src.sv
// model of the external trigger and gate signal source
`timescale 1ns/100ps
module sgt_ext_src (
  input wire logic want_lvl,
  output logic ext_lvl
);
  // ----------------------------------------------------------------------
  // source output
  // ----------------------------------------------------------------------
  // the source has its own timing, so edges land off the bench clock grid
  initial begin
    ext_lvl = 1'h0;
  end
  always @(want_lvl) begin
    #3.7 ext_lvl = want_lvl;
  end
endmodule : sgt_ext_src

//--- testbench/sgt_ctrl_tb_top.sv
// self-checking bench for the sweep gate and trigger control block
`timescale 1ns/100ps
module sgt_ctrl_tb_top;
  import sgt_pkg::*;
  logic mclk;
  logic nrst;
  sgt_bus_t bus;
  logic [1:0] det;
  logic [31:0] swp;
  logic want;
  logic ext;
  logic smp;
  logic [31:0] rdata;
  sgt_stat_t status;
  logic [4:0] st;
  logic sok;
  logic rd_seen;
  logic smp_seen;
  logic [31:0] rq[$];
  logic sq[$];
  logic [31:0] seed;
  logic [31:0] v;
  int fails;
  int samples_checked;
  int cyc;
  int n;
  logic [3:0] ra[9] = '{A_FILT, A_RBW, A_CPL, A_GCTL, A_GDLY, A_GLEN,
                        A_TCTL, A_TOFS, 4'hf};
  logic [31:0] re[9] = '{32'h1, 32'h6, 32'h3, 32'h0, 32'h0, GATE_LEN_RST,
                         32'h0, 32'h0, 32'h0};
  logic [1:0] fc[5] = '{F_CHAN, F_WEIGHT, F_DEF6, F_WEIGHT_ALT, F_GAUSS};
  assign st = status;
  sgt_ctrl dut_u (.MCLK(mclk), .NRST(nrst), .BUS(bus), .DETECTOR(det),
    .SWEEP_TICKS(swp), .EXT_IN(ext), .SAMPLE_IN(smp), .RDATA(rdata),
    .STATUS(status), .SAMPLE_OK(sok));
  sgt_ext_src src_u (.want_lvl(want), .ext_lvl(ext));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'h1, 1'h0};
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'h0, 1'h1};
    rq.push_back(e);
    @(posedge mclk);
  endtask : rd
  task automatic sample(input logic e);
    bus <= '0;
    smp <= 1'h1;
    sq.push_back(e);
    @(posedge mclk);
    smp <= 1'h0;
    @(posedge mclk);
  endtask : sample
  // waits at most 200 cycles; a stuck flag then fails its bound check
  task automatic wt(input int b, input logic e, output int k);
    bus <= '0;
    k = 0;
    @(negedge mclk);
    while (st[b] !== e && k < 200) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
  endtask : wt
  task automatic pause(input int c);
    bus <= '0;
    repeat (c) @(posedge mclk);
  endtask : pause
  // ----------------------------------------------------------------------
  // watcher and timeout
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd_seen) cmp32(rdata, rq.pop_front());
    if (smp_seen) cmp1(sok, sq.pop_front());
    rd_seen <= bus.rd;
    smp_seen <= smp;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    nrst = 1'h0;
    bus = '0;
    det = 2'h0;
    swp = 32'h0;
    want = 1'h0;
    smp = 1'h0;
    rd_seen = 1'h0;
    smp_seen = 1'h0;
    seed = 32'h14;
    cyc = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
    for (int d = 0; d < 4; d++) begin
      det <= d[1:0];
      pause(4);
      @(negedge mclk);
      cmp1(st[1], d != 0);
      cmp1(st[0], 1'h1);
      @(posedge mclk);
    end
    wr(A_RBW, 32'h8);
    rd(A_CPL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(A_FILT, {30'h0, fc[i]});
      rd(A_FILT, {30'h0, fc[i]});
    end
    v = xs() % (GATE_DLY_MAX + 32'h1);
    wr(A_GDLY, v);
    rd(A_GDLY, v);
    wr(A_GDLY, 32'h0);
    v = xs() % (TRIG_OFS_MAX + 32'h1);
    wr(A_TOFS, v);
    rd(A_TOFS, v);
    wr(A_GLEN, GATE_LEN_MIN);
    rd(A_GLEN, GATE_LEN_MIN);
    swp <= (xs() & 32'hffff) | 32'h10;
    wr(A_TCTL, 32'h2);
    wr(A_TOFS, 32'hffff_fffe);
    rd(A_TOFS, 32'hffff_fffe);
    wr(A_TCTL, 32'h0);
    sample(1'h1);
    // level mode, negative polarity: a high pin is the inactive level
    wr(A_GCTL, 32'h7);
    want <= 1'h1;
    pause(10);
    sample(1'h0);
    want <= 1'h0;
    wt(4, 1'h1, n);
    cmp1(n < 10, 1'h1);
    sample(1'h1);
    wr(A_GLEN, 32'h4);
    wr(A_GCTL, 32'h1);
    pause(10);
    want <= 1'h1;
    wt(4, 1'h1, n);
    cmp1(n < 10, 1'h1);
    wt(4, 1'h0, n);
    cmp1(n + 5 >= 4 * TICK_CYC && n <= 4 * TICK_CYC + 5, 1'h1);
    sample(1'h0);
    wr(A_GCTL, 32'h0);
    want <= 1'h0;
    pause(10);
    wr(A_TOFS, 32'h2);
    wr(A_TCTL, 32'h4);
    wr(A_CMD, 32'h1);
    wt(2, 1'h1, n);
    cmp1(n < 10, 1'h1);
    wr(A_GDLY, 32'h5);
    pause(2);
    want <= 1'h1;
    wt(2, 1'h0, n);
    cmp1(n < 20, 1'h1);
    wt(3, 1'h1, n);
    cmp1(n + 7 >= 2 * TICK_CYC && n <= 2 * TICK_CYC + 8, 1'h1);
    rd(A_GDLY, 32'h0);
    wr(A_GDLY, 32'h5);
    wr(A_TCTL, 32'h9);
    wr(A_CMD, 32'h1);
    wt(2, 1'h1, n);
    cmp1(n < 10, 1'h1);
    want <= 1'h0;
    wt(2, 1'h0, n);
    cmp1(n < 20, 1'h1);
    wt(3, 1'h1, n);
    cmp1(n + 7 >= 7 * TICK_CYC && n <= 7 * TICK_CYC + 8, 1'h1);
    pause(4);
    tally_and_finish();
  end
endmodule : sgt_ctrl_tb_top
